// ---- rtl/phy_mgmt_defines.svh ----
/*
  Register offsets, field positions and reset values for the
  PHY management register bank.
  Assumes inclusion by bare name from the package and the bank module.
*/
`ifndef PHY_MGMT_DEFINES_SVH
`define PHY_MGMT_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_EXPANSION 5'h06
`define OFS_RSVD_LO 5'h08
`define OFS_RSVD_HI 5'h0F
`define OFS_STATUS_CTRL 5'h10
`define OFS_SPECIAL_CTRL 5'h11
`define OFS_RSVD_18 5'h12

// ****************************************
// Field positions
// ****************************************
`define EXP_PD_FAULT 4
`define EXP_LP_NP 3
`define EXP_LOC_NP 2
`define EXP_PAGE_RX 1
`define EXP_LP_AN 0
`define STC_RPD_DIS 13
`define STC_SYNC 11
`define STC_TX_PD 10
`define STC_10T_PD 9
`define STC_POL 8
`define STC_ADDR_HI 6
`define STC_ADDR_LO 2
`define STC_SPEED 1
`define STC_DUPLEX 0

// ****************************************
// Reset values
// ****************************************
`define RST_EXPANSION 16'h0000
`define RST_STC_RW 16'h2000
`define STC_RW_MASK 16'hF000
`define RST_SPECIAL 16'h0000

`endif

// ---- rtl/phy_mgmt_pkg.sv ----
/*
  Types shared by the PHY management register bank.
  Assumes the defines header is on the include path.
*/
package phy_mgmt_pkg;
  `include "phy_mgmt_defines.svh"
  typedef logic [15:0] reg_word_t;
  typedef logic [4:0] reg_addr_t;
endpackage : phy_mgmt_pkg

// ---- rtl/phy_management_registers.sv ----
/*
  Management register bank: negotiation expansion, reserved range, PHY status
  and control, PHY special control and reserved register 18.
  Assumes a management frame engine on mclk presents one-cycle read and write
  strobes with a 5-bit register address; status inputs are asynchronous levels
  or pulses from the PHY datapath and are synchronised here.
*/
`timescale 1ns/1ps
`include "phy_mgmt_defines.svh"

module phy_management_registers
  import phy_mgmt_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire phy_mgmt_pkg::reg_addr_t reg_addr,
  input wire logic wr_strobe,
  input wire phy_mgmt_pkg::reg_word_t wr_data,
  input wire logic rd_strobe,
  output phy_mgmt_pkg::reg_word_t rd_data,
  input wire logic pd_fault_event,
  input wire logic page_rx_event,
  input wire logic lp_an_able,
  input wire logic lp_np_able,
  input wire logic loc_np_able,
  input wire logic rx_in_sync,
  input wire logic tx100_powered_down,
  input wire logic t10_powered_down,
  input wire logic rx_polarity_reversed,
  input wire logic [4:0] phy_addr_pins,
  input wire logic speed_100,
  input wire logic full_duplex,
  output logic rpd_disable,
  output logic scrambler_bypass,
  output logic enc_4b5b_bypass,
  output logic force_h_pattern,
  output logic force_34_pattern,
  output logic force_link_valid,
  output logic symbol_err_enable,
  output logic carrier_sense_disable,
  output logic dyn_pd_disable,
  output logic an_loopback,
  output logic tx_tristate,
  output logic force_polarity,
  output logic auto_pol_disable,
  output logic squelch_disable,
  output logic ext_squelch,
  output logic link_integ_disable,
  output logic jabber_disable
);
  import phy_mgmt_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int SYNC_W = 16;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic pd_fault_last;
  logic page_rx_last;
  logic [4:0] sampled_addr;
  logic addr_taken;

  // Not reset, so the strap is already settled when reset lets go
  always_ff @(posedge mclk) begin
    if (clk_en) begin
      sync_a <= {pd_fault_event, page_rx_event, lp_an_able, lp_np_able, loc_np_able,
                 rx_in_sync, tx100_powered_down, t10_powered_down,
                 rx_polarity_reversed, phy_addr_pins, speed_100, full_duplex};
      sync_b <= sync_a;
    end
  end

  wire s_pd_fault = sync_b[15];
  wire s_page_rx = sync_b[14];
  wire s_lp_an = sync_b[13];
  wire s_lp_np = sync_b[12];
  wire s_loc_np = sync_b[11];
  wire s_sync = sync_b[10];
  wire s_tx_pd = sync_b[9];
  wire s_10t_pd = sync_b[8];
  wire s_pol = sync_b[7];
  wire [4:0] s_addr = sync_b[6:2];
  wire s_speed = sync_b[1];
  wire s_duplex = sync_b[0];

  // Address is a strap: caught once, after reset release, from the synced copy
  always_ff @(posedge mclk) begin
    if (reset) begin
      sampled_addr <= 5'h00;
      addr_taken <= 1'b0;
    end else if (clk_en && !addr_taken) begin
      sampled_addr <= s_addr;
      addr_taken <= 1'b1;
    end
  end

  // ****************************************
  // Latch-high flags
  // ****************************************
  logic latch_high_flag_pdf;
  logic latch_high_flag_pg;
  wire pdf_rise = s_pd_fault && !pd_fault_last;
  wire pg_rise = s_page_rx && !page_rx_last;
  wire exp_read = clk_en && rd_strobe && (reg_addr == `OFS_EXPANSION);

  always_ff @(posedge mclk) begin
    if (reset) begin
      pd_fault_last <= 1'b0;
      page_rx_last <= 1'b0;
    end else if (clk_en) begin
      pd_fault_last <= s_pd_fault;
      page_rx_last <= s_page_rx;
    end
  end

  // A new event in the read cycle wins, so it is never lost
  always_ff @(posedge mclk) begin
    if (reset) begin
      latch_high_flag_pdf <= 1'b0;
    end else if (clk_en) begin
      if (pdf_rise) begin
        latch_high_flag_pdf <= 1'b1;
      end else if (exp_read) begin
        latch_high_flag_pdf <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      latch_high_flag_pg <= 1'b0;
    end else if (clk_en) begin
      if (pg_rise) begin
        latch_high_flag_pg <= 1'b1;
      end else if (exp_read) begin
        latch_high_flag_pg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Writable registers
  // ****************************************
  reg_word_t stc_rw;
  reg_word_t special;

  // Only bits 15:12 of status/control are storage; the rest ignore writes
  always_ff @(posedge mclk) begin
    if (reset) begin
      stc_rw <= `RST_STC_RW;
    end else if (clk_en && wr_strobe && reg_addr == `OFS_STATUS_CTRL) begin
      stc_rw <= wr_data & `STC_RW_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      special <= `RST_SPECIAL;
    end else if (clk_en && wr_strobe && reg_addr == `OFS_SPECIAL_CTRL) begin
      special <= wr_data;
    end
  end

  always_comb begin
    rpd_disable = stc_rw[`STC_RPD_DIS];
    scrambler_bypass = special[15];
    enc_4b5b_bypass = special[14];
    force_h_pattern = special[13];
    force_34_pattern = special[12];
    force_link_valid = special[11];
    symbol_err_enable = special[10];
    carrier_sense_disable = special[9];
    dyn_pd_disable = special[8];
    an_loopback = special[7];
    tx_tristate = special[6];
    force_polarity = special[5];
    auto_pol_disable = special[4];
    squelch_disable = special[3];
    ext_squelch = special[2];
    link_integ_disable = special[1];
    jabber_disable = special[0];
  end

  // ****************************************
  // Read path
  // ****************************************
  function automatic reg_word_t read_word(input reg_addr_t a);
    reg_word_t w;
    w = 16'h0000;
    if (a == `OFS_EXPANSION) begin
      w[`EXP_PD_FAULT] = latch_high_flag_pdf;
      w[`EXP_LP_NP] = s_lp_np;
      w[`EXP_LOC_NP] = s_loc_np;
      w[`EXP_PAGE_RX] = latch_high_flag_pg;
      w[`EXP_LP_AN] = s_lp_an;
    end else if (a == `OFS_STATUS_CTRL) begin
      w = stc_rw;
      w[`STC_SYNC] = s_sync;
      w[`STC_TX_PD] = s_tx_pd;
      w[`STC_10T_PD] = s_10t_pd;
      w[`STC_POL] = s_pol;
      w[`STC_ADDR_HI:`STC_ADDR_LO] = sampled_addr;
      w[`STC_SPEED] = s_speed;
      w[`STC_DUPLEX] = s_duplex;
    end else if (a == `OFS_SPECIAL_CTRL) begin
      w = special;
    end
    // Reserved 8-15, 18 and unmapped addresses all read zero
    return w;
  endfunction : read_word

  // Data is captured on the read strobe and held until the next read
  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_data <= 16'h0000;
    end else if (clk_en && rd_strobe) begin
      rd_data <= read_word(reg_addr);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_exp_upper_zero:
    assert property (@(posedge mclk) disable iff (reset)
      $past(clk_en && rd_strobe && reg_addr == `OFS_EXPANSION) |-> rd_data[15:5] == 11'h0)
    else $error("Expansion upper bits not zero");

  a_rsvd_reads_zero:
    assert property (@(posedge mclk) disable iff (reset)
      clk_en && rd_strobe && (reg_addr == `OFS_RSVD_18 ||
      (reg_addr >= `OFS_RSVD_LO && reg_addr <= `OFS_RSVD_HI)) |=> rd_data == 16'h0000)
    else $error("Reserved register read not zero");

  a_pdf_clears_read:
    assert property (@(posedge mclk) disable iff (reset)
      exp_read && !pdf_rise |=> !latch_high_flag_pdf)
    else $error("Fault flag survived read");

  a_pdf_sets:
    assert property (@(posedge mclk) disable iff (reset)
      clk_en && pdf_rise |=> latch_high_flag_pdf)
    else $error("Fault flag not latched");

  a_page_sets:
    assert property (@(posedge mclk) disable iff (reset)
      clk_en && pg_rise |=> latch_high_flag_pg)
    else $error("Page flag not latched");

  a_page_holds:
    assert property (@(posedge mclk) disable iff (reset)
      latch_high_flag_pg && !exp_read |=> latch_high_flag_pg)
    else $error("Page flag dropped without read");

  a_rpd_reset_one:
    assert property (@(posedge mclk)
      $past(reset) |-> rpd_disable)
    else $error("Reduced power disable not one after reset");

  a_special_write:
    assert property (@(posedge mclk) disable iff (reset)
      clk_en && wr_strobe && reg_addr == `OFS_SPECIAL_CTRL |=>
      {scrambler_bypass, jabber_disable} == {$past(wr_data[15]), $past(wr_data[0])})
    else $error("Special control write not applied");

  a_stc_ro_ignored:
    assert property (@(posedge mclk) disable iff (reset)
      clk_en && wr_strobe && reg_addr == `OFS_STATUS_CTRL |=>
      stc_rw == ($past(wr_data) & `STC_RW_MASK))
    else $error("Status control write not masked");

  a_stc_write:
    assert property (@(posedge mclk) disable iff (reset)
      clk_en && wr_strobe && reg_addr == `OFS_STATUS_CTRL |=>
      rpd_disable == $past(wr_data[`STC_RPD_DIS]))
    else $error("Reduced power disable write not applied");

  a_pg_clears_read:
    assert property (@(posedge mclk) disable iff (reset)
      exp_read && !pg_rise |=> !latch_high_flag_pg)
    else $error("Page flag survived read");

  a_exp_ro_ignored:
    assert property (@(posedge mclk) disable iff (reset)
      clk_en && wr_strobe && reg_addr == `OFS_EXPANSION &&
      !exp_read && !pdf_rise && !pg_rise |=>
      {latch_high_flag_pdf, latch_high_flag_pg} ==
      $past({latch_high_flag_pdf, latch_high_flag_pg}))
    else $error("Expansion flags changed by write");

  a_addr_held:
    assert property (@(posedge mclk) disable iff (reset)
      addr_taken |=> $stable(sampled_addr))
    else $error("Sampled address changed after capture");

  a_rd_holds:
    assert property (@(posedge mclk) disable iff (reset)
      !(clk_en && rd_strobe) |=> $stable(rd_data))
    else $error("Read data changed without a read");

  a_freeze_ctrl:
    assert property (@(posedge mclk) disable iff (reset)
      !clk_en |=> $stable(special) && $stable(stc_rw))
    else $error("Control changed while clock enable low");

endmodule : phy_management_registers

// ---- tb/mgmt_master_model.sv ----
/*
  Station management controller model: one-cycle read and write strobes.
  Assumes the bank takes strobes on rising mclk with clk_en high.
*/
`timescale 1ns/1ps
module mgmt_master_model
  import phy_mgmt_pkg::*;
(
  input wire logic mclk,
  output phy_mgmt_pkg::reg_addr_t reg_addr,
  output logic wr_strobe,
  output phy_mgmt_pkg::reg_word_t wr_data,
  output logic rd_strobe,
  input wire phy_mgmt_pkg::reg_word_t rd_data
);
  import phy_mgmt_pkg::*;

  // ****************************************
  // Access tasks
  // ****************************************
  initial begin
    reg_addr = 5'h00;
    wr_strobe = 1'b0;
    wr_data = 16'h0000;
    rd_strobe = 1'b0;
  end

  // Whole word per access; data inverted after release so stale values never match
  task automatic wr(input reg_addr_t a, input reg_word_t d);
    @(negedge mclk);
    reg_addr = a;
    wr_data = d;
    wr_strobe = 1'b1;
    @(negedge mclk);
    wr_strobe = 1'b0;
    wr_data = ~d;
  endtask : wr

  // Read data is sampled one edge after the strobe is taken
  task automatic rd(input reg_addr_t a, output reg_word_t d);
    @(negedge mclk);
    reg_addr = a;
    rd_strobe = 1'b1;
    @(negedge mclk);
    rd_strobe = 1'b0;
    d = rd_data;
  endtask : rd
endmodule : mgmt_master_model

// ---- tb/phy_management_registers_tb_top.sv ----
/*
  Self-checking bench for the PHY management register bank.
  Assumes the status inputs settle within four enabled edges.
*/
`timescale 1ns/1ps
module phy_management_registers_tb_top
  import phy_mgmt_pkg::*;
;
  // ****************************************
  // Stimulus and checking
  // ****************************************
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  reg_addr_t reg_addr;
  reg_word_t wr_data, rd_data, v;
  logic wr_strobe, rd_strobe, rpd;
  logic pd_ev = 1'b0;
  logic pg_ev = 1'b0;
  logic [2:0] an_lv = 3'b000;
  logic [3:0] st4 = 4'b0110;
  logic [4:0] pins = 5'h15;
  logic [1:0] sd = 2'b00;
  wire [15:0] ctl;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;

  always #4 mclk = ~mclk;

  mgmt_master_model mgmt_master_model_i (.mclk(mclk), .reg_addr(reg_addr),
    .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_strobe(rd_strobe), .rd_data(rd_data));

  phy_management_registers phy_management_registers_i (.mclk(mclk), .reset(reset),
    .clk_en(clk_en), .reg_addr(reg_addr), .wr_strobe(wr_strobe), .wr_data(wr_data),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .pd_fault_event(pd_ev),
    .page_rx_event(pg_ev), .lp_an_able(an_lv[0]), .lp_np_able(an_lv[1]),
    .loc_np_able(an_lv[2]), .rx_in_sync(st4[3]), .tx100_powered_down(st4[2]),
    .t10_powered_down(st4[1]), .rx_polarity_reversed(st4[0]), .phy_addr_pins(pins),
    .speed_100(sd[1]), .full_duplex(sd[0]), .rpd_disable(rpd),
    .scrambler_bypass(ctl[15]), .enc_4b5b_bypass(ctl[14]), .force_h_pattern(ctl[13]),
    .force_34_pattern(ctl[12]), .force_link_valid(ctl[11]), .symbol_err_enable(ctl[10]),
    .carrier_sense_disable(ctl[9]), .dyn_pd_disable(ctl[8]), .an_loopback(ctl[7]),
    .tx_tristate(ctl[6]), .force_polarity(ctl[5]), .auto_pol_disable(ctl[4]),
    .squelch_disable(ctl[3]), .ext_squelch(ctl[2]), .link_integ_disable(ctl[1]),
    .jabber_disable(ctl[0]));

  function automatic reg_word_t exp16(input reg_word_t rw);
    return rw | {4'h0, st4, 1'b0, pins, sd};
  endfunction : exp16

  task automatic chk(input string name, input reg_word_t seen, input reg_word_t exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // Ceiling well above the fewer than two hundred cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (10) @(negedge mclk);
    reset = 1'b0;
    mgmt_master_model_i.rd(5'h06, v);
    chk("exp_reset", v, 16'h0000);
    mgmt_master_model_i.rd(5'h10, v);
    chk("stc_reset", v, exp16(16'h2000));
    chk("rpd_reset", {15'h0000, rpd}, 16'h0001);
    mgmt_master_model_i.rd(5'h11, v);
    chk("spc_reset", v, 16'h0000);
    chk("ctl_reset", ctl, 16'h0000);
    mgmt_master_model_i.wr(5'h10, 16'hFFFF);
    mgmt_master_model_i.rd(5'h10, v);
    chk("stc_ones", v, exp16(16'hF000));
    mgmt_master_model_i.wr(5'h10, 16'h0000);
    chk("rpd_clear", {15'h0000, rpd}, 16'h0000);
    for (int p = 0; p < 2; p++) begin
      st4 = p ? 4'b1001 : 4'b0110;
      sd = p ? 2'b10 : 2'b01;
      repeat (4) @(negedge mclk);
      mgmt_master_model_i.rd(5'h10, v);
      chk("stc_live", v, exp16(16'h0000));
    end
    an_lv = 3'b111;
    pd_ev = 1'b1;
    pg_ev = 1'b1;
    repeat (4) @(negedge mclk);
    pd_ev = 1'b0;
    pg_ev = 1'b0;
    mgmt_master_model_i.wr(5'h06, 16'h0000);
    mgmt_master_model_i.rd(5'h06, v);
    chk("exp_flags", v, 16'h001F);
    mgmt_master_model_i.rd(5'h06, v);
    chk("exp_cleared", v, 16'h000D);
    for (int i = 0; i < 16; i++) begin
      mgmt_master_model_i.wr(5'h11, 16'h0001 << i);
      mgmt_master_model_i.rd(5'h11, v);
      chk("spc_bit", v, 16'h0001 << i);
      chk("ctl_bit", ctl, 16'h0001 << i);
    end
    // Frozen clock enable: neither the write nor the read may land
    clk_en = 1'b0;
    mgmt_master_model_i.wr(5'h11, 16'h00FF);
    mgmt_master_model_i.rd(5'h10, v);
    clk_en = 1'b1;
    chk("frozen_rd", v, 16'h8000);
    chk("frozen_ctl", ctl, 16'h8000);
    // Mid-run reset brings the controls back to their defaults
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    chk("ctl_rst2", ctl, 16'h0000);
    chk("rpd_rst2", {15'h0000, rpd}, 16'h0001);
    mgmt_master_model_i.rd(5'h10, v);
    chk("stc_rst2", v, exp16(16'h2000));
    // Reserved places ignore writes and read zero, register 6 upper bits too
    for (int a = 8; a <= 18; a++) begin
      if (a < 16 || a == 18) begin
        mgmt_master_model_i.wr(a[4:0], 16'hFFFF);
        mgmt_master_model_i.rd(a[4:0], v);
        chk("rsvd", v, 16'h0000);
      end
    end
    mgmt_master_model_i.wr(5'h06, 16'hFFFF);
    mgmt_master_model_i.rd(5'h06, v);
    chk("exp_ro", v, 16'h000D);
    give_verdict();
  end
endmodule : phy_management_registers_tb_top
